/* rds_consts.vh */
`ifndef RDS_CONSTS_VH
`define RDS_CONSTS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RDS_A_CTRL 4'h0
`define RDS_A_SUBID 4'h1
`define RDS_A_CATEN 4'h2
`define RDS_A_STAT 4'h3
`define RDS_A_MASK 4'h4
`define RDS_A_TRBL 4'h5
`define RDS_A_QLVL 4'h6
// ----------------------------------------
// Control fields
// ----------------------------------------
`define RDS_CTRL_DLY_HI 3
`define RDS_CTRL_DLY_LO 0
`define RDS_CTRL_PRIO 4
`define RDS_CTRL_DUAL 5
`define RDS_CTRL_SPLIT 6
`define RDS_CTRL_TRBL_EN 7
`define RDS_CTRL_ADDR_HI 12
`define RDS_CTRL_ADDR_LO 8
// ----------------------------------------
// Status bits
// ----------------------------------------
`define RDS_ST_DONE 0
`define RDS_ST_TRBL 1
`define RDS_ST_DROP 2
`define RDS_ST_W 3
// ----------------------------------------
// Event codes and format
// ----------------------------------------
`define RDS_CODE_TRBL 12'h0333
`define RDS_CODE_ANT 12'h0357
`define RDS_CODE_TAMP 12'h0341
`define RDS_FMT_CID 1'b1
`define RDS_TRBL_ANT 5
`define RDS_STEP_S 15
// ----------------------------------------
// Timing
// ----------------------------------------
`define RDS_CLK_HZ 200000000
`define RDS_TICK_S 1
`endif

/* rds_prio_arb.v */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Fixed priority pick among simultaneous events
// ----------------------------------------
module rds_prio_arb #(
  parameter N = 9
) (
  input wire [N-1:0] req_i,
  output reg [N-1:0] gnt_o
);
  integer k;
  reg found;
  always @* begin
    gnt_o = {N{1'b0}};
    found = 1'b0;
    for (k = 0; k < N; k = k + 1) begin
      if (req_i[k] && !found) begin
        gnt_o[k] = 1'b1; // [R8]
        found = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* rds_fifo.v */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Arrival-order report queue
// ----------------------------------------
module rds_fifo #(
  parameter W = 20,
  parameter AW = 3
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire push_i,
  input wire [W-1:0] din_i,
  input wire pop_i,
  output wire [W-1:0] dout_o,
  output wire empty_o,
  output wire full_o,
  output wire [AW:0] level_o
);
  reg [W-1:0] mem [0:(1<<AW)-1];
  reg [AW:0] wp_q;
  reg [AW:0] rp_q;
  wire do_push = push_i && !full_o;
  wire do_pop = pop_i && !empty_o;
  assign level_o = wp_q - rp_q;
  assign empty_o = (wp_q == rp_q);
  assign full_o = (level_o[AW] == 1'b1);
  assign dout_o = mem[rp_q[AW-1:0]];
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end else if (ce_i) begin
      if (do_push) begin
        mem[wp_q[AW-1:0]] <= din_i; // [R7]
        wp_q <= wp_q + 1'b1;
      end
      if (do_pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* rds_dispatch.v */
// Functional notes
// [R1] After the first send, wait a delay of 0 to 225 s in 15 s steps before the second.
// [R2] A priority bit picks the first target: 0 dialer, 1 communicator.
// [R3] Dialer first and acknowledged in time: the report is dropped, never to the communicator.
// [R4] Unacknowledged at expiry: the report goes to both dialer and communicator.
// [R5] Communicator reports always use the Contact ID format.
// [R6] Communicator forwarding needs the category and the individual event enabled.
// [R7] Communicator reports leave the queue in arrival order.
// [R8] Simultaneous events go out in fixed priority, fire alarm first.
// [R9] An unprogrammed subscriber identity suppresses its communicator reports.
// [R10] Dual mode sends the head event to primary and secondary before the next.
// [R11] Split mode steers each report only to the station assigned to its type.
// [R12] Link loss or device trouble may be configured to send a trouble report.
// [R13] Every communicator trouble raises a check indication with the device bus address; check_o follows link loss and the seven troubles, not tamper.
// [R14] Troubles use code 333, antenna fault 357, tamper 341.
// [R15] The communicator reports seven distinct trouble conditions.
// [R16] The delay counts one-second ticks; a zero setting sends to the second target at once.
`timescale 1ns/10ps
`include "rds_consts.vh"
`default_nettype none
module rds_dispatch #(
  parameter NCAT = 9,
  parameter CW = 12,
  parameter AW = 3,
  parameter TICK_CYC = `RDS_CLK_HZ * `RDS_TICK_S
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire ce_i,
  // Register port
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  // Event sources, one per priority class, bit 0 is fire alarm
  input wire [NCAT-1:0] evt_i,
  input wire [CW-1:0] evt_code_i,
  input wire evt_en_i,
  input wire evt_split_sec_i,
  // Dialer path
  output reg dial_req_o,
  output reg [CW-1:0] dial_code_o,
  input wire dial_ack_i,
  // Communicator path
  output reg comm_req_o,
  output reg [CW-1:0] comm_code_o,
  output reg comm_sec_o,
  output reg comm_fmt_o,
  input wire comm_done_i,
  // Communicator supervision
  input wire link_lost_i,
  input wire [6:0] comm_trbl_i,
  input wire comm_tamper_i,
  output reg check_o,
  output reg [4:0] check_addr_o,
  output wire irq_o
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [15:0] ctrl_q;
  reg [1:0] subid_q;
  reg [NCAT-1:0] caten_q;
  reg [`RDS_ST_W-1:0] stat_q;
  reg [`RDS_ST_W-1:0] mask_q;
  reg [7:0] trbl_q;
  wire [AW:0] qlvl;
  wire [3:0] dly_set = ctrl_q[`RDS_CTRL_DLY_HI:`RDS_CTRL_DLY_LO];
  wire prio_comm = ctrl_q[`RDS_CTRL_PRIO];
  wire dual = ctrl_q[`RDS_CTRL_DUAL];
  wire split = ctrl_q[`RDS_CTRL_SPLIT];
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_q <= 16'h0000;
      subid_q <= 2'b00;
      caten_q <= {NCAT{1'b0}};
      mask_q <= {`RDS_ST_W{1'b0}};
    end else if (ce_i && wr_i) begin
      case (addr_i)
        `RDS_A_CTRL: ctrl_q <= wdata_i;
        `RDS_A_SUBID: subid_q <= wdata_i[1:0];
        `RDS_A_CATEN: caten_q <= wdata_i[NCAT-1:0];
        `RDS_A_MASK: mask_q <= wdata_i[`RDS_ST_W-1:0];
        default: ;
      endcase
    end
  end
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (ce_i) begin
      rdata_o <= 16'h0000;
      if (rd_i) begin
        case (addr_i)
          `RDS_A_CTRL: rdata_o <= ctrl_q;
          `RDS_A_SUBID: rdata_o <= {14'h0000, subid_q};
          `RDS_A_CATEN: rdata_o <= {{(16-NCAT){1'b0}}, caten_q};
          `RDS_A_STAT: rdata_o <= {{(16-`RDS_ST_W){1'b0}}, stat_q};
          `RDS_A_MASK: rdata_o <= {{(16-`RDS_ST_W){1'b0}}, mask_q};
          `RDS_A_TRBL: rdata_o <= {8'h00, trbl_q};
          `RDS_A_QLVL: rdata_o <= {{(15-AW){1'b0}}, qlvl};
          default: rdata_o <= 16'h0000;
        endcase
      end
    end
  end
  // ----------------------------------------
  // Event intake
  // ----------------------------------------
  // Only the highest class of a simultaneous set is queued; lower ones must be held by the source
  wire [NCAT-1:0] gnt;
  rds_prio_arb #(.N(NCAT)) u_arb (
    .req_i(evt_i),
    .gnt_o(gnt)
  );
  wire evt_any = |evt_i;
  wire cat_ok = |(gnt & caten_q) && evt_en_i; // [R6]
  // Outside split mode every report goes to the primary station, so only its identity counts
  wire sub_ok = (split && evt_split_sec_i) ? subid_q[1] : subid_q[0]; // [R9]
  // Entry: code, secondary flag, communicator enable
  wire [CW+1:0] q_in = {evt_code_i, evt_split_sec_i, cat_ok & sub_ok};
  // A trouble report takes the queue slot; an event in that same cycle must be held by its source
  wire trbl_rise;
  wire [CW-1:0] trbl_code;
  wire q_push = trbl_rise || (evt_any && evt_en_i); // [R12]
  wire [CW+1:0] q_din = trbl_rise ? {trbl_code, 2'b00} : q_in;
  wire [CW+1:0] q_out;
  wire q_empty;
  wire q_full;
  reg q_pop;
  rds_fifo #(.W(CW+2), .AW(AW)) u_q (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .push_i(q_push),
    .din_i(q_din),
    .pop_i(q_pop),
    .dout_o(q_out),
    .empty_o(q_empty),
    .full_o(q_full),
    .level_o(qlvl)
  );
  wire h_comm = q_out[0];
  wire h_sec = q_out[1];
  wire [CW-1:0] h_code = q_out[CW+1:2];
  // ----------------------------------------
  // Acknowledgement delay timebase
  // ----------------------------------------
  // One-second tick keeps the delay counter small at the cost of up to 1 s jitter
  reg [31:0] pre_q;
  reg tick_q;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      pre_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (ce_i) begin
      tick_q <= (pre_q == TICK_CYC - 1);
      pre_q <= (pre_q == TICK_CYC - 1) ? 32'h0000_0000 : pre_q + 1'b1; // [R16]
    end
  end
  // ----------------------------------------
  // Dispatch sequencer
  // ----------------------------------------
  localparam S_IDLE = 5'b00001;
  localparam S_FIRST = 5'b00010;
  localparam S_WAIT = 5'b00100;
  localparam S_BOTH = 5'b01000;
  localparam S_SEC = 5'b10000;
  reg [4:0] st_q;
  reg [7:0] sec_q;
  reg dial_done_q;
  reg comm_fin_q;
  wire [31:0] dly_prod = dly_set * `RDS_STEP_S;
  wire [7:0] dly_sec = dly_prod[7:0]; // [R1]
  reg ev_done;
  reg ev_drop;
  // Communicator target per mode: split uses the entry's station, else primary
  wire c_sec = split ? h_sec : 1'b0; // [R11]
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      sec_q <= 8'h00;
      dial_req_o <= 1'b0;
      comm_req_o <= 1'b0;
      dial_code_o <= {CW{1'b0}};
      comm_code_o <= {CW{1'b0}};
      comm_sec_o <= 1'b0;
      comm_fmt_o <= `RDS_FMT_CID;
      dial_done_q <= 1'b0;
      comm_fin_q <= 1'b0;
      q_pop <= 1'b0;
      ev_done <= 1'b0;
      ev_drop <= 1'b0;
    end else if (ce_i) begin
      q_pop <= 1'b0;
      ev_done <= 1'b0;
      ev_drop <= 1'b0;
      comm_fmt_o <= `RDS_FMT_CID; // [R5]
      case (st_q)
        S_IDLE: begin
          if (!q_empty && !q_pop) begin
            sec_q <= 8'h00;
            dial_code_o <= h_code;
            comm_code_o <= h_code;
            comm_sec_o <= c_sec;
            dial_done_q <= 1'b0;
            comm_fin_q <= !h_comm;
            if (prio_comm && h_comm) begin
              comm_req_o <= 1'b1; // [R2]
            end else begin
              dial_req_o <= 1'b1; // [R2]
            end
            st_q <= S_FIRST;
          end
        end
        S_FIRST: begin
          dial_req_o <= 1'b0;
          comm_req_o <= 1'b0;
          st_q <= S_WAIT;
        end
        S_WAIT: begin
          if (!prio_comm && dial_ack_i) begin
            q_pop <= 1'b1; // [R3]
            ev_drop <= 1'b1;
            st_q <= S_IDLE;
          end else if (prio_comm && comm_done_i && !dual) begin
            q_pop <= 1'b1;
            ev_done <= 1'b1;
            st_q <= S_IDLE;
          end else if (sec_q >= dly_sec) begin
            dial_req_o <= 1'b1; // [R4]
            comm_req_o <= h_comm; // [R4]
            st_q <= S_BOTH;
          end else if (tick_q) begin
            sec_q <= sec_q + 1'b1; // [R16]
          end
        end
        S_BOTH: begin
          dial_req_o <= 1'b0;
          comm_req_o <= 1'b0;
          if (dial_ack_i) begin
            dial_done_q <= 1'b1;
          end
          if (comm_done_i) begin
            comm_fin_q <= 1'b1;
          end
          if ((dial_done_q || dial_ack_i) && (comm_fin_q || comm_done_i)) begin
            if (dual && !split && h_comm && subid_q[1]) begin
              comm_sec_o <= 1'b1; // [R10]
              comm_req_o <= 1'b1; // [R10]
              st_q <= S_SEC;
            end else begin
              q_pop <= 1'b1;
              ev_done <= 1'b1;
              st_q <= S_IDLE;
            end
          end
        end
        S_SEC: begin
          comm_req_o <= 1'b0;
          if (comm_done_i && !comm_req_o) begin
            q_pop <= 1'b1; // [R10]
            ev_done <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // Communicator supervision
  // ----------------------------------------
  wire [7:0] trbl_now = {link_lost_i, comm_trbl_i}; // [R15]
  wire trbl_any = |trbl_now || comm_tamper_i;
  reg trbl_seen_q;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      trbl_q <= 8'h00;
      check_o <= 1'b0;
      check_addr_o <= 5'h00;
      trbl_seen_q <= 1'b0;
    end else if (ce_i) begin
      trbl_q <= trbl_now;
      trbl_seen_q <= trbl_any && ctrl_q[`RDS_CTRL_TRBL_EN]; // [R12]
      check_o <= |trbl_now; // [R13]
      check_addr_o <= ctrl_q[`RDS_CTRL_ADDR_HI:`RDS_CTRL_ADDR_LO]; // [R13]
    end
  end
  // Tamper outranks an antenna fault, which outranks every other trouble
  assign trbl_code = comm_tamper_i ? `RDS_CODE_TAMP :
    (comm_trbl_i[`RDS_TRBL_ANT] ? `RDS_CODE_ANT : `RDS_CODE_TRBL); // [R14]
  // Only the first cycle of a trouble queues a report, so a lasting fault is sent once
  assign trbl_rise = trbl_any && ctrl_q[`RDS_CTRL_TRBL_EN] && !trbl_seen_q; // [R12]
  // ----------------------------------------
  // Interrupt status, cleared by reading, set wins
  // ----------------------------------------
  wire [`RDS_ST_W-1:0] st_set = {ev_drop, trbl_rise, ev_done};
  wire st_rd = rd_i && (addr_i == `RDS_A_STAT);
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      stat_q <= {`RDS_ST_W{1'b0}};
    end else if (ce_i) begin
      stat_q <= (st_rd ? {`RDS_ST_W{1'b0}} : stat_q) | st_set;
    end
  end
  assign irq_o = |(stat_q & mask_q);
  wire unused_ok = q_full;
endmodule
`default_nettype wire

/* rds_chk_assertions.sv */
`timescale 1ns/10ps
`include "rds_consts.vh"
`default_nettype none
// ----
// Port checks of the dispatcher
// ----
module rds_chk (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic link_lost_i,
  input wire logic [6:0] comm_trbl_i,
  input wire logic dial_req_o,
  input wire logic comm_req_o,
  input wire logic comm_sec_o,
  input wire logic comm_fmt_o,
  input wire logic check_o,
  input wire logic [4:0] check_addr_o
);
  logic [15:0] ctrl_q;
  // Mirror of the control word, so mode checks need no hierarchy
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_q <= 16'h0000;
    end else if (ce_i && wr_i && addr_i == `RDS_A_CTRL) begin
      ctrl_q <= wdata_i;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  chk_fmt_cid: assert property (comm_req_o |-> comm_fmt_o)
    else $error("communicator report not in Contact ID format");
  chk_trbl_check: assert property (ce_i && (|comm_trbl_i) |=> check_o)
    else $error("trouble without check indication");
  chk_link_check: assert property (ce_i && link_lost_i |=> check_o)
    else $error("link loss without check indication");
  chk_check_addr: assert property ((ce_i && wr_i && addr_i == `RDS_A_CTRL) ##1 !wr_i
    |-> ##1 check_addr_o == $past(wdata_i[12:8], 2))
    else $error("check address differs from programmed address");
  chk_dial_pulse: assert property (dial_req_o |=> !dial_req_o)
    else $error("dialer request longer than one cycle");
  chk_comm_pulse: assert property (comm_req_o |=> !comm_req_o)
    else $error("communicator request longer than one cycle");
  chk_sec_mode: assert property (comm_req_o && comm_sec_o
    |-> ctrl_q[`RDS_CTRL_DUAL] || ctrl_q[`RDS_CTRL_SPLIT])
    else $error("secondary station used outside dual or split mode");
  // First dialer pulse comes two cycles before the resend to both targets
  chk_zero_delay: assert property ($rose(comm_req_o) && !comm_sec_o && ctrl_q[4:0] == 5'h00
    |-> dial_req_o && $past(dial_req_o, 2))
    else $error("zero delay did not resend at once");
endmodule
bind rds_dispatch rds_chk u_chk (.ref_clk_i, .rst_i, .ce_i, .addr_i, .wdata_i, .wr_i,
  .link_lost_i, .comm_trbl_i, .dial_req_o, .comm_req_o, .comm_sec_o, .comm_fmt_o,
  .check_o, .check_addr_o);
`default_nettype wire

/* rds_comm_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----
// Far end: logs requests, answers after a set latency
// ----
module rds_comm_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic [11:0] code_i,
  input wire logic sec_i,
  input wire logic [7:0] lat_i,
  output logic done_o
);
  logic [11:0] codes [$];
  logic secs [$];
  logic [7:0] cnt_q;
  // A new request restarts the wait, as a busy far end would
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      cnt_q <= 8'h00;
    end else if (req_i) begin
      codes.push_back(code_i);
      secs.push_back(sec_i);
      cnt_q <= lat_i;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
      done_o <= (cnt_q == 8'h01);
    end
  end
endmodule
`default_nettype wire

/* test_rds_dispatch.sv */
`timescale 1ns/10ps
`default_nettype none
module test_rds_dispatch;
  logic ref_clk_i = 0, rst_i = 1, ce_i = 1, wr_i = 0, rd_i = 0, link_lost_i = 0;
  logic [3:0] addr_i = '0;
  logic [15:0] wdata_i = '0, rdata_o, rv;
  logic [8:0] evt_i = '0, cat;
  logic [11:0] evt_code_i = '0, dial_code_o, comm_code_o, code;
  logic [11:0] q [3];
  logic evt_en_i = 0, evt_split_sec_i = 0, comm_tamper_i = 0, en, sec, sp;
  logic [6:0] comm_trbl_i = '0;
  logic [7:0] dlat = 8'h08, clat = 8'h03;
  logic [1:0] sub;
  logic dial_req_o, dial_ack_i, comm_req_o, comm_sec_o, comm_fmt_o, comm_done_i, check_o, irq_o;
  logic [4:0] check_addr_o;
  int mismatches = 0, samples_checked = 0, n, m, e, cls;
  always #2.5 ref_clk_i = ~ref_clk_i;
  // ----
  // Design and far ends
  // ----
  rds_dispatch #(.TICK_CYC(10)) DUT (.ref_clk_i, .rst_i, .ce_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .evt_i, .evt_code_i, .evt_en_i, .evt_split_sec_i, .dial_req_o,
    .dial_code_o, .dial_ack_i, .comm_req_o, .comm_code_o, .comm_sec_o, .comm_fmt_o,
    .comm_done_i, .link_lost_i, .comm_trbl_i, .comm_tamper_i, .check_o, .check_addr_o,
    .irq_o);
  rds_comm_model DIAL (.clk_i(ref_clk_i), .rst_i, .req_i(dial_req_o), .code_i(dial_code_o),
    .sec_i(1'b0), .lat_i(dlat), .done_o(dial_ack_i));
  rds_comm_model COMM (.clk_i(ref_clk_i), .rst_i, .req_i(comm_req_o), .code_i(comm_code_o),
    .sec_i(comm_sec_o), .lat_i(clat), .done_o(comm_done_i));
  // ----
  // Tasks and expectations
  // ----
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run(input int c);
    repeat (c) @(posedge ref_clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    run(1);
    wr_i <= 1'b0;
    run(1);
  endtask
  // Read data stand one cycle only, so sample just after the edge
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    run(1);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    run(1);
  endtask
  task automatic ev(input int c, input logic [11:0] k, input logic n_en, input logic s);
    evt_i <= 9'h001 << c;
    evt_code_i <= k;
    evt_en_i <= n_en;
    evt_split_sec_i <= s;
    run(1);
    evt_i <= 9'h000;
  endtask
  function automatic int fwd(logic [8:0] c, logic [1:0] s, int k, logic n_en, logic t, logic p);
    return (n_en && c[k] && s[p ? t : 1'b0]) ? 1 : 0;
  endfunction
  task automatic stop_test;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    e = $urandom(23623);
    run(20);
    rst_i <= 1'b0;
    run(1);
    rd(4'hF, rv);
    cmp(rv, 16'h0000);
    wr(4'h1, 16'h0003);
    wr(4'h2, 16'h01FF);
    wr(4'h4, 16'h0006);
    wr(4'h0, 16'h1581);
    dlat <= 8'h05;
    n = COMM.codes.size();
    ev(2, 12'h130, 1'b1, 1'b0);
    run(200);
    cmp(16'(COMM.codes.size() - n), 16'h0000);
    cmp(16'(irq_o), 16'h0001);
    rd(4'h3, rv);
    cmp(rv & 16'h0004, 16'h0004);
    cmp(16'(irq_o), 16'h0000);
    wr(4'h0, 16'h1591);
    n = COMM.codes.size();
    m = DIAL.codes.size();
    ev(1, 12'h121, 1'b1, 1'b0);
    run(60);
    cmp(16'(COMM.codes.size() - n), 16'h0001);
    cmp(16'(DIAL.codes.size() - m), 16'h0000);
    clat <= 8'd200;
    ev(4, 12'h144, 1'b1, 1'b0);
    run(420);
    cmp(16'(COMM.codes.size() - n), 16'h0003);
    cmp(16'(DIAL.codes.size() - m), 16'h0001);
    clat <= 8'h03;
    dlat <= 8'h08;
    for (int i = 0; i < 16; i++) begin
      cat = 9'h1FF ^ (9'h001 << ($urandom % 12));
      sub = ($urandom % 4 == 0) ? 2'($urandom) : 2'h3;
      cls = $urandom % 9;
      en = ($urandom % 4) != 0;
      sec = 1'($urandom);
      sp = 1'($urandom);
      code = 12'($urandom);
      wr(4'h0, 16'h1580 | (16'(sp) << 6));
      wr(4'h1, 16'(sub));
      wr(4'h2, 16'(cat));
      n = COMM.codes.size();
      ev(cls, code, en, sec);
      run(40);
      e = fwd(cat, sub, cls, en, sec, sp);
      cmp(16'(COMM.codes.size() - n), 16'(e));
      if (e == 1) begin
        cmp(16'(COMM.codes[n]), 16'(code));
        cmp(16'(COMM.secs[n]), 16'(sp & sec));
      end
    end
    wr(4'h0, 16'h1580);
    wr(4'h1, 16'h0003);
    wr(4'h2, 16'h01FF);
    n = COMM.codes.size();
    for (int k = 0; k < 3; k++) begin
      q[k] = 12'($urandom);
      ev(3, q[k], 1'b1, 1'b0);
      run(2);
    end
    run(150);
    for (int k = 0; k < 3; k++) begin
      cmp(16'(COMM.codes[n + k]), 16'(q[k]));
    end
    wr(4'h0, 16'h15A0);
    n = COMM.codes.size();
    ev(0, 12'h0A5, 1'b1, 1'b0);
    run(80);
    cmp(16'(COMM.codes.size() - n), 16'h0002);
    cmp(16'({COMM.secs[n], COMM.secs[n + 1]}), 16'h0001);
    cmp(16'(COMM.codes[n + 1]), 16'h00A5);
    // A write while frozen must be lost; the irq checks below need mask 6 to survive it
    ce_i <= 1'b0;
    wr(4'h4, 16'h0000);
    ce_i <= 1'b1;
    m = DIAL.codes.size();
    // Seven communicator troubles, then link loss in the top bit
    for (int b = 0; b < 8; b++) begin
      rd(4'h3, rv);
      {link_lost_i, comm_trbl_i} <= 8'h01 << b;
      run(3);
      cmp(16'(check_o), 16'h0001);
      cmp(16'(check_addr_o), 16'h0015);
      cmp(16'(irq_o), 16'h0001);
      rd(4'h5, rv);
      cmp(rv, 16'h0001 << b);
      {link_lost_i, comm_trbl_i} <= 8'h00;
      run(3);
    end
    comm_tamper_i <= 1'b1;
    run(3);
    comm_tamper_i <= 1'b0;
    run(150);
    // Each trouble report reaches the dialer twice: first leg, then the zero-delay resend
    cmp(16'(DIAL.codes.size() - m), 16'h0012);
    for (int k = 0; k < 9; k++) begin
      rv = (k == 8) ? 16'h0341 : (k == 5) ? 16'h0357 : 16'h0333;
      cmp(16'(DIAL.codes[m + 2 * k]), rv);
    end
    rd(4'h3, rv);
    cmp(16'(irq_o), 16'h0000);
    stop_test();
  end
endmodule
`default_nettype wire
